// *** rtl/pmie_top.sv ***
// Power-mode sequencer: idle entry, wake, start delays, status flags
//
// Functional notes
// - Primary idle: CPU stops, peripherals on primary, primary-ready stays set.
// - Primary idle wake: CPU on primary after start delay, bits unchanged.
// - Idle with select 01: primary off, ready cleared, secondary-running set.
// - Secondary idle sleep ignored when secondary oscillator enable is clear.
// - Peripheral clocks withheld until secondary oscillator oscillates.
// - Secondary idle wake: CPU resumes on secondary after start delay.
// - Internal idle entry shuts primary and clears primary-ready.
// - Non-zero frequency or low-freq select enables output, stable after settling.
// - Already stable internal output keeps stable flag, no new settling.
// - All-zero frequency and low-freq select: output off, stable flag clear.
// - Internal idle wake resumes on internal; low-freq osc kept for watchdog/monitor.
// - Sleep or idle left only on interrupt, reset or watchdog time-out.
// - Only enabled interrupt sources wake, on their flag becoming set.
// - Interrupt wake branches to vector only with global enable set.
// - Every exit inserts fixed CPU start delay before execution resumes.
// - Watchdog time-out wakes when idle or asleep, resets when running.
// - Watchdog clears on sleep, clear command, clock loss, frequency write.
// - Reset held through start-up timer, then ready flag set.
// - Two-speed or monitor: run on internal until primary ready or sleep.
// - Sleep with idle-enable clear stops oscillator, clears all source flags.
// - Start-up timer counts 1024 primary periods; PLL lock about 2 ms.
`timescale 1ns/1ps
`default_nettype none
module pmie_top #(
  parameter int unsigned PLL_LOCK_CYC =
    pmie_pkg::PLL_LOCK_US * 1000 / pmie_pkg::CLK_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  int_flag_i,
  input  wire logic        wdt_timeout_i,
  input  wire logic        clock_lost_i,
  input  wire logic        prim_osc_tick_i,
  input  wire logic        sec_osc_running_i,
  input  wire logic        pri_crystal_i,
  input  wire logic        pll_en_i,
  input  wire logic        two_speed_en_i,
  input  wire logic        fscm_en_i,
  input  wire logic        wdt_en_i,
  output logic             cpu_clk_en_o,
  output logic             periph_clk_en_o,
  output logic             cpu_reset_o,
  output logic [1:0]       clk_src_o,
  output logic             primary_osc_en_o,
  output logic             internal_osc_en_o,
  output logic             low_freq_osc_en_o,
  output logic             resume_o,
  output logic             vector_o,
  output logic             wdt_reset_o,
  output logic             wdt_clear_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pmie_pkg::pmie_mode_t mode;
    pmie_pkg::pmie_src_t  src;
    logic [8:0]           ctrl;
    logic [7:0]           inten;
    logic                 prdy;
    logic                 srun;
    logic                 istb;
    logic                 settle;
    logic                 ost_run;
    logic                 tsel_pri;
    logic                 ts;
    logic                 pri_on;
    logic                 int_wake;
    logic                 wdt_wake;
    logic                 ack;
    logic [31:0]          rdat;
    logic                 resume;
    logic                 vec;
    logic                 wdt_rst;
    logic                 wdt_clr;
  } pmie_st_t;

  pmie_st_t    s;
  pmie_st_t    next_s;
  pmie_tmr_if  csd_if ();
  pmie_tmr_if  ost_if ();
  logic        int_wake;
  logic        wr;
  logic        slp;
  logic        clr;
  logic        fq_wr;
  logic [31:0] wmask;
  logic [1:0]  sel;
  logic        idle_en;
  logic        int_on;

  pmie_timer u_csd (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (csd_if)
  );

  pmie_timer u_ost (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (ost_if)
  );

  pmie_wake u_wake (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .int_flag_i (int_flag_i),
    .int_en_i   (s.inten),
    .wake_o     (int_wake)
  );

  assign sel     = s.ctrl[pmie_pkg::CTRL_SEL +: 2];
  assign idle_en = s.ctrl[pmie_pkg::CTRL_IDLE];
  assign int_on  = (s.ctrl[pmie_pkg::CTRL_FREQ +: 3] != 3'h0)
                || s.ctrl[pmie_pkg::CTRL_LFSRC];
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr      = s.ack && wb_cyc_i && wb_stb_i && wb_we_i;
  assign slp     = wr && wb_adr_i == pmie_pkg::ADR_CMD && wb_sel_i[0]
                && wb_dat_i[pmie_pkg::CMD_SLEEP];
  assign clr     = wr && wb_adr_i == pmie_pkg::ADR_CMD && wb_sel_i[0]
                && wb_dat_i[pmie_pkg::CMD_WATCHDOG_CLEAR_INSTR];
  assign fq_wr   = wr && wb_adr_i == pmie_pkg::ADR_CTRL && wb_sel_i[0]
                && s.src == pmie_pkg::SRC_INT;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    next_s        = s;
    csd_if.load   = 1'b0;
    csd_if.count  = pmie_pkg::CSD_CNT;
    csd_if.tick   = 1'b1;
    ost_if.load   = 1'b0;
    ost_if.count  = pmie_pkg::OST_CNT;
    ost_if.tick   = s.tsel_pri ? prim_osc_tick_i : 1'b1;
    next_s.ack    = wb_cyc_i && wb_stb_i && !s.ack;
    next_s.rdat   = 32'h0000_0000;
    next_s.resume = 1'b0;
    next_s.vec    = 1'b0;
    next_s.wdt_rst = 1'b0;
    // Watchdog clear sources
    next_s.wdt_clr = clr || fq_wr || (clock_lost_i && fscm_en_i)
                  || (slp && s.mode == pmie_pkg::M_RUN);

    case (wb_adr_i)
      pmie_pkg::ADR_CTRL: begin
        next_s.rdat[8:0] = s.ctrl;
      end
      pmie_pkg::ADR_STAT: begin
        next_s.rdat[pmie_pkg::ST_PRDY]     = s.prdy;
        next_s.rdat[pmie_pkg::ST_SRUN]     = s.srun;
        next_s.rdat[pmie_pkg::ST_ISTB]     = s.istb;
        next_s.rdat[pmie_pkg::ST_MODE +: 3] = s.mode;
        next_s.rdat[pmie_pkg::ST_CPU]      = s.mode == pmie_pkg::M_RUN;
        next_s.rdat[pmie_pkg::ST_WDTW]     = s.wdt_wake;
        next_s.rdat[pmie_pkg::ST_SETTLE]   = s.settle;
      end
      pmie_pkg::ADR_INTEN: begin
        next_s.rdat[7:0] = s.inten;
      end
      default: begin
        next_s.rdat = 32'h0000_0000;
      end
    endcase

    if (wr && wb_adr_i == pmie_pkg::ADR_CTRL) begin
      next_s.ctrl = (s.ctrl & ~wmask[8:0]) | (wb_dat_i[8:0] & wmask[8:0]);
    end
    if (wr && wb_adr_i == pmie_pkg::ADR_INTEN) begin
      next_s.inten = (s.inten & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
    end

    // Internal output settled
    if (s.settle && !s.tsel_pri && ost_if.done) begin
      next_s.istb   = 1'b1;
      next_s.settle = 1'b0;
    end

    case (s.mode)
      pmie_pkg::M_RESET: begin
        if (!s.ost_run) begin
          // Start-up timer counts primary periods from reset release
          ost_if.load     = pri_crystal_i;
          next_s.tsel_pri = 1'b1;
          next_s.ost_run  = pri_crystal_i;
          next_s.pri_on   = 1'b1;
          if (two_speed_en_i || fscm_en_i) begin
            next_s.mode = pmie_pkg::M_RUN;
            next_s.src  = pmie_pkg::SRC_INT;
            next_s.ts   = 1'b1;
            next_s.istb = 1'b1;
          end
        end else if (ost_if.done) begin
          next_s.ost_run = 1'b0;
          if (pll_en_i) begin
            ost_if.load     = 1'b1;
            ost_if.count    = 16'(PLL_LOCK_CYC);
            next_s.tsel_pri = 1'b0;
            next_s.mode     = pmie_pkg::M_PLL;
          end else begin
            next_s.mode = pmie_pkg::M_RUN;
            next_s.src  = pmie_pkg::SRC_PRI;
            next_s.prdy = 1'b1;
          end
        end
        if (!s.ost_run && !pri_crystal_i && !two_speed_en_i
            && !fscm_en_i) begin
          next_s.mode = pmie_pkg::M_RUN;
          next_s.src  = pmie_pkg::SRC_PRI;
          next_s.prdy = 1'b1;
        end
      end
      pmie_pkg::M_PLL: begin
        if (ost_if.done) begin
          next_s.mode = pmie_pkg::M_RUN;
          next_s.src  = pmie_pkg::SRC_PRI;
          next_s.prdy = 1'b1;
        end
      end
      pmie_pkg::M_RUN: begin
        if (wdt_timeout_i) begin
          next_s.wdt_rst = 1'b1;
        end
        // Two-speed hand-over once the primary is ready
        if (s.ts && s.ost_run && ost_if.done) begin
          next_s.ts      = 1'b0;
          next_s.ost_run = 1'b0;
          next_s.src     = pmie_pkg::SRC_PRI;
          next_s.prdy    = 1'b1;
          next_s.istb    = 1'b0;
        end
        if (slp) begin
          next_s.int_wake = 1'b0;
          next_s.wdt_wake = 1'b0;
          if (s.ts) begin
            next_s.ts      = 1'b0;
            next_s.ost_run = 1'b0;
            next_s.pri_on  = 1'b0;
          end
          if (!idle_en) begin
            next_s.mode   = pmie_pkg::M_SLEEP;
            next_s.src    = pmie_pkg::SRC_NONE;
            next_s.pri_on = 1'b0;
            next_s.prdy   = 1'b0;
            next_s.srun   = 1'b0;
            next_s.istb   = 1'b0;
            next_s.settle = 1'b0;
          end else if (sel == pmie_pkg::SEL_PRI) begin
            next_s.mode   = pmie_pkg::M_IDLE;
            if (s.src != pmie_pkg::SRC_PRI || s.ts) begin
              next_s.src  = pmie_pkg::SRC_PRI;
              next_s.pri_on = 1'b1;
            end
          end else if (sel == pmie_pkg::SEL_SEC) begin
            if (s.ctrl[pmie_pkg::CTRL_SECEN]) begin
              next_s.mode   = pmie_pkg::M_IDLE;
              next_s.src    = pmie_pkg::SRC_SEC;
              next_s.pri_on = 1'b0;
              next_s.prdy   = 1'b0;
              next_s.srun   = 1'b1;
              next_s.istb   = 1'b0;
            end
          end else begin
            next_s.mode   = pmie_pkg::M_IDLE;
            next_s.src    = pmie_pkg::SRC_INT;
            next_s.pri_on = 1'b0;
            next_s.prdy   = 1'b0;
            next_s.srun   = 1'b0;
            if (!int_on) begin
              next_s.istb   = 1'b0;
              next_s.settle = 1'b0;
            end else if (!s.istb) begin
              ost_if.load     = 1'b1;
              ost_if.count    = pmie_pkg::IOBST_CNT;
              next_s.tsel_pri = 1'b0;
              next_s.settle   = 1'b1;
            end
          end
        end
      end
      pmie_pkg::M_IDLE,
      pmie_pkg::M_SLEEP: begin
        if (s.src == pmie_pkg::SRC_INT && !int_on) begin
          next_s.istb   = 1'b0;
          next_s.settle = 1'b0;
        end
        // Only interrupt or watchdog end the low-power state here
        if (int_wake || wdt_timeout_i) begin
          csd_if.load     = 1'b1;
          next_s.mode     = pmie_pkg::M_WAKE;
          next_s.int_wake = int_wake;
          next_s.wdt_wake = wdt_timeout_i && !int_wake;
          if (s.mode == pmie_pkg::M_SLEEP) begin
            if (sel == pmie_pkg::SEL_PRI) begin
              next_s.src      = pmie_pkg::SRC_PRI;
              next_s.pri_on   = 1'b1;
              ost_if.load     = pri_crystal_i;
              next_s.tsel_pri = 1'b1;
              next_s.ost_run  = pri_crystal_i;
              next_s.prdy     = !pri_crystal_i;
            end else if (sel == pmie_pkg::SEL_SEC) begin
              next_s.src  = pmie_pkg::SRC_SEC;
              next_s.srun = 1'b1;
            end else begin
              next_s.src = pmie_pkg::SRC_INT;
              if (int_on) begin
                ost_if.load     = 1'b1;
                ost_if.count    = pmie_pkg::IOBST_CNT;
                next_s.tsel_pri = 1'b0;
                next_s.settle   = 1'b1;
              end
            end
          end
        end
      end
      pmie_pkg::M_WAKE: begin
        if (s.ost_run && ost_if.done) begin
          next_s.ost_run = 1'b0;
          next_s.prdy    = 1'b1;
        end
        if (csd_if.done && (!s.ost_run || ost_if.done)) begin
          next_s.mode   = pmie_pkg::M_RUN;
          next_s.resume = 1'b1;
          next_s.vec    = s.int_wake && s.ctrl[pmie_pkg::CTRL_GIE];
        end
      end
      default: begin
        next_s.mode = pmie_pkg::M_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s       <= '0;
      s.mode  <= pmie_pkg::M_RESET;
      s.src   <= pmie_pkg::SRC_NONE;
      s.ctrl  <= pmie_pkg::CTRL_RST;
      s.inten <= pmie_pkg::INTEN_RST;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign wb_dat_o          = s.rdat;
  assign wb_ack_o          = s.ack;
  assign cpu_clk_en_o      = s.mode == pmie_pkg::M_RUN;
  assign periph_clk_en_o   = (s.mode == pmie_pkg::M_RUN)
    || ((s.mode == pmie_pkg::M_IDLE || s.mode == pmie_pkg::M_WAKE)
        && !(s.src == pmie_pkg::SRC_SEC && !sec_osc_running_i)
        && !s.ost_run);
  assign cpu_reset_o       = s.mode == pmie_pkg::M_RESET
                          || s.mode == pmie_pkg::M_PLL;
  assign clk_src_o         = s.src;
  assign primary_osc_en_o  = s.pri_on;
  assign internal_osc_en_o = s.ts || (s.src == pmie_pkg::SRC_INT && int_on);
  assign low_freq_osc_en_o = wdt_en_i || fscm_en_i
                          || s.src == pmie_pkg::SRC_INT;
  assign resume_o          = s.resume;
  assign vector_o          = s.vec;
  assign wdt_reset_o       = s.wdt_rst;
  assign wdt_clear_o       = s.wdt_clr;

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] wk_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || s.mode != pmie_pkg::M_WAKE) begin
      wk_cnt <= 16'h0000;
    end else begin
      wk_cnt <= wk_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for two cycles");
  a_primary_idle_rdy: assert property (
    s.mode == pmie_pkg::M_RUN && slp && idle_en && sel == pmie_pkg::SEL_PRI
    && s.prdy |=> s.mode == pmie_pkg::M_IDLE && s.prdy && !cpu_clk_en_o)
    else $error("primary idle lost ready flag");
  a_sec_entry: assert property (
    s.mode == pmie_pkg::M_RUN && slp && idle_en && sel == pmie_pkg::SEL_SEC
    && s.ctrl[pmie_pkg::CTRL_SECEN]
    |=> s.srun && !s.prdy && !primary_osc_en_o)
    else $error("secondary idle entry flags wrong");
  a_sec_ignored: assert property (
    s.mode == pmie_pkg::M_RUN && slp && idle_en && sel == pmie_pkg::SEL_SEC
    && !s.ctrl[pmie_pkg::CTRL_SECEN] |=> s.mode == pmie_pkg::M_RUN)
    else $error("sleep not ignored without secondary enable");
  a_sleep_flags: assert property (
    s.mode == pmie_pkg::M_RUN && slp && !idle_en
    |=> s.mode == pmie_pkg::M_SLEEP && !s.prdy && !s.srun && !s.istb
        && !primary_osc_en_o && !periph_clk_en_o)
    else $error("sleep left a source flag or oscillator on");
  a_start_delay: assert property (
    resume_o |-> wk_cnt > pmie_pkg::CSD_CNT && cpu_clk_en_o)
    else $error("execution resumed before start delay");
  a_wdt_run_rst: assert property (
    s.mode == pmie_pkg::M_RUN && wdt_timeout_i |=> wdt_reset_o)
    else $error("run-mode time-out did not reset");
  a_wdt_idle_wake: assert property (
    (s.mode == pmie_pkg::M_IDLE || s.mode == pmie_pkg::M_SLEEP)
    && wdt_timeout_i |=> s.mode == pmie_pkg::M_WAKE && !wdt_reset_o)
    else $error("idle time-out did not wake");
  a_wdt_clr_slp: assert property (
    s.mode == pmie_pkg::M_RUN && slp |=> wdt_clear_o)
    else $error("sleep did not clear watchdog");
  a_vec_gie: assert property (
    vector_o |-> $past(s.int_wake) && s.ctrl[pmie_pkg::CTRL_GIE])
    else $error("vector taken without interrupt wake and enable");
  a_idle_mode_hold: assert property (
    s.mode == pmie_pkg::M_IDLE && (int_wake || wdt_timeout_i)
    |=> $stable(s.src) ##[1:300] resume_o)
    else $error("idle wake changed source or never resumed");

  c_idle_entry: cover property (s.mode == pmie_pkg::M_RUN ##1
                                s.mode == pmie_pkg::M_IDLE);
  c_int_wake: cover property (s.mode == pmie_pkg::M_WAKE && s.int_wake
                              ##[1:300] resume_o);
  c_wdt_reset: cover property (wdt_reset_o);
  c_sleep: cover property (s.mode == pmie_pkg::M_SLEEP);
endmodule
`default_nettype wire

// *** rtl/pmie_pkg.sv ***
// Shared constants and types for the power-managed idle exit sequencer
package pmie_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_STAT  = 8'h04;
  localparam logic [7:0] ADR_CMD   = 8'h08;
  localparam logic [7:0] ADR_INTEN = 8'h0C;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_W      = 9;
  localparam int CTRL_IDLE   = 0;
  localparam int CTRL_SEL    = 1;
  localparam int CTRL_FREQ   = 3;
  localparam int CTRL_LFSRC  = 6;
  localparam int CTRL_GIE    = 7;
  localparam int CTRL_SECEN  = 8;
  localparam logic [8:0] CTRL_RST  = 9'h000;
  localparam logic [7:0] INTEN_RST = 8'h00;

  // ****************************************
  // Status register fields
  // ****************************************
  localparam int ST_PRDY   = 0;
  localparam int ST_SRUN   = 1;
  localparam int ST_ISTB   = 2;
  localparam int ST_MODE   = 4;
  localparam int ST_CPU    = 8;
  localparam int ST_WDTW   = 9;
  localparam int ST_SETTLE = 10;

  // ****************************************
  // Command register bits
  // ****************************************
  localparam int CMD_SLEEP  = 0;
  localparam int CMD_WATCHDOG_CLEAR_INSTR = 1;

  localparam logic [1:0] SEL_PRI = 2'h0;
  localparam logic [1:0] SEL_SEC = 2'h1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TMR_W       = 16;
  localparam int CLK_NS      = 100;
  localparam int CSD_NS      = 2000;
  localparam int IOBST_NS    = 1000;
  localparam int OST_PERIODS = 1024;
  localparam int PLL_LOCK_US = 2000;
  localparam logic [15:0] CSD_CNT   = 16'((CSD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] IOBST_CNT = 16'((IOBST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] OST_CNT   = 16'(OST_PERIODS);

  typedef enum logic [2:0] {
    M_RESET, M_PLL, M_RUN, M_IDLE, M_SLEEP, M_WAKE
  } pmie_mode_t;

  typedef enum logic [1:0] {
    SRC_NONE, SRC_PRI, SRC_SEC, SRC_INT
  } pmie_src_t;

endpackage

// *** rtl/pmie_tmr_if.sv ***
// Load/tick/done link between the sequencer and a delay timer
`timescale 1ns/1ps
`default_nettype none
interface pmie_tmr_if;
  logic        load;
  logic [15:0] count;
  logic        tick;
  logic        done;
  modport owner (output load, count, tick, input done);
  modport timer (input load, count, tick, output done);
endinterface
`default_nettype wire

// *** rtl/pmie_timer.sv ***
// Down counter that times one delay per load
`timescale 1ns/1ps
`default_nettype none
module pmie_timer (
  input  wire logic   clk_i,
  input  wire logic   rst_i,
  pmie_tmr_if.timer   t
);
  typedef struct packed {
    logic [15:0] cnt;
  } pmie_tmr_st_t;

  pmie_tmr_st_t s;
  pmie_tmr_st_t next_s;

  always_comb begin
    next_s = s;
    if (t.load) begin
      next_s.cnt = t.count;
    end else if (t.tick && s.cnt != 16'h0000) begin
      next_s.cnt = s.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign t.done = (s.cnt == 16'h0000) && !t.load;
endmodule
`default_nettype wire

// *** rtl/pmie_wake.sv ***
// Per-source interrupt wake detector
`timescale 1ns/1ps
`default_nettype none
module pmie_wake (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] int_flag_i,
  input  wire logic [7:0] int_en_i,
  output logic            wake_o
);
  typedef struct packed {
    logic [7:0] prev;
  } pmie_wk_st_t;

  pmie_wk_st_t s;
  pmie_wk_st_t next_s;
  logic [7:0]  rise;

  // Enabled source whose flag has just become set
  for (genvar i = 0; i < 8; i++) begin : g_src
    assign rise[i] = int_flag_i[i] && !s.prev[i] && int_en_i[i];
  end

  always_comb begin
    next_s      = s;
    next_s.prev = int_flag_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wake_o = |rise;
endmodule
`default_nettype wire

// *** sim/pmie_tb_top.sv ***
// Self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module pmie_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, wdt = 1'b0, lost = 1'b0, tick = 1'b0;
  logic        srun = 1'b1, wdt_en = 1'b0, ack, cpu_en, per_en;
  logic        resume, vector, wdt_rst, fscm = 1'b0, wclr, cpu_rst;
  logic        pri_en, iosc, lf_en;
  logic [1:0]  src;
  logic [7:0]  adr = 8'h00, flag = 8'h00;
  logic [31:0] dat = 32'h0000_0000, rd, q;
  int          failures = 0, checked = 0;
  pmie_top #(.PLL_LOCK_CYC(50)) u_pmie_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .int_flag_i(flag),
    .wdt_timeout_i(wdt), .clock_lost_i(lost), .prim_osc_tick_i(tick),
    .sec_osc_running_i(srun), .pri_crystal_i(1'b0), .pll_en_i(1'b0),
    .two_speed_en_i(1'b0), .fscm_en_i(fscm), .wdt_en_i(wdt_en),
    .cpu_clk_en_o(cpu_en), .periph_clk_en_o(per_en), .cpu_reset_o(cpu_rst),
    .clk_src_o(src), .primary_osc_en_o(pri_en), .internal_osc_en_o(iosc),
    .low_freq_osc_en_o(lf_en), .resume_o(resume), .vector_o(vector),
    .wdt_reset_o(wdt_rst), .wdt_clear_o(wclr));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tick <= ~tick;
  end
  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic wbx(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task automatic wdt_pulse();
    @(posedge clk_i) wdt <= 1'b1;
    @(posedge clk_i) wdt <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_resume(input logic vec);
    int n;
    n = 0;
    while (resume !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    `CHK(resume, 1'b1)
    `CHK(vector, vec)
    `CHK(cpu_en, 1'b1)
  endtask
  task automatic complete_run();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge clk_i);
    `CHK(cpu_rst, 1'b1)
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK(cpu_rst, 1'b0)
    wdt_en <= 1'b1;
    wbx(0, 8'h00, 0); `CHK(q[8:0], 9'h000)
    wbx(0, 8'h04, 0); `CHK(q[0], 1'b1)
    wbx(0, 8'h10, 0); `CHK(q, 32'h0000_0000)
    `CHK(lf_en, 1'b1)
    wdt_pulse(); `CHK(wdt_rst, 1'b1)
    wbx(1, 8'h0C, 32'h0000_0001);
    wbx(1, 8'h00, 32'h0000_0081);
    wbx(1, 8'h08, 32'h0000_0001);
    @(posedge clk_i) flag <= 8'h02;
    repeat (30) @(posedge clk_i);
    wbx(0, 8'h04, 0); `CHK(q[6:4], 3'h3)
    `CHK(q[0], 1'b1)
    `CHK(cpu_en, 1'b0)
    `CHK(pri_en, 1'b1)
    `CHK(src, 2'h1)
    @(posedge clk_i) flag <= 8'h03;
    wait_resume(1'b1);
    wbx(0, 8'h00, 0); `CHK(q[8:0], 9'h081)
    flag <= 8'h00;
    wbx(1, 8'h00, 32'h0000_0003);
    wbx(1, 8'h08, 32'h0000_0001);
    wbx(0, 8'h04, 0); `CHK(q[6:4], 3'h2)
    srun <= 1'b0;
    wbx(1, 8'h00, 32'h0000_0103);
    wbx(1, 8'h08, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    `CHK(per_en, 1'b0)
    wbx(0, 8'h04, 0); `CHK(q[2:0], 3'h2)
    `CHK(src, 2'h2)
    `CHK(pri_en, 1'b0)
    srun <= 1'b1;
    repeat (2) @(posedge clk_i);
    `CHK(per_en, 1'b1)
    wdt_pulse();
    wait_resume(1'b0);
    wbx(0, 8'h04, 0); `CHK(q[9], 1'b1)
    `CHK(q[1], 1'b1)
    wbx(1, 8'h00, 32'h0000_0000);
    wbx(1, 8'h08, 32'h0000_0001);
    wbx(0, 8'h04, 0); `CHK(q[6:4], 3'h4)
    `CHK(q[2:0], 3'h0)
    @(posedge clk_i) begin
      lost <= 1'b1;
      fscm <= 1'b1;
    end
    @(posedge clk_i) lost <= 1'b0;
    @(posedge clk_i);
    `CHK(wclr, 1'b1)
    repeat (19) @(posedge clk_i);
    wbx(0, 8'h04, 0); `CHK(q[6:4], 3'h4)
    @(posedge clk_i) flag <= 8'h01;
    wait_resume(1'b0);
    wbx(1, 8'h00, 32'h0000_000D);
    wbx(1, 8'h08, 32'h0000_0001);
    repeat (15) @(posedge clk_i);
    wbx(0, 8'h04, 0); `CHK(q[2:0], 3'h4)
    `CHK(q[6:4], 3'h3)
    `CHK(src, 2'h3)
    `CHK(iosc, 1'b1)
    flag <= 8'h00;
    @(posedge clk_i) flag <= 8'h01;
    wait_resume(1'b0);
    `CHK(src, 2'h3)
    complete_run();
  end
endmodule
`default_nettype wire
